// *** src/dpd_clock_ctrl.sv ***
// frequency word decode, channel routing and power-down control
// Operation
// - word: index, feedback, post select, reference
// - feedback plus three, reference plus two
// - post divide is two to select
// - index 1110 video off, 1111 borrow
// - index 1111 stops video vco
// - borrowed vco uses video post divisor
// - pin low, mode zero: standby one
// - standby one: vcos stop, video high
// - standby one: memory clock from divider
// - divider values 1-15 give 32 down to 4
// - standby two: outputs and oscillator off
// - registers kept through standby two
// - pin high returns to normal
// - control bit 21 selects standby mode
// - bits 13-15 pick prescale per register
module dpd_clock_ctrl
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // frequency word load
    input  wire logic                          word_we,
    input  wire logic [1:0]                    word_addr,
    input  wire logic [dpd_pkg::WORD_W-1:0]    word_data,
    input  wire logic                          video_select,
    // control word and standby divider load
    input  wire logic                          control_word_we,
    input  wire logic [dpd_pkg::CTRL_W-1:0]    control_word,
    input  wire logic                          standby_div_we,
    input  wire logic [3:0]                    standby_div_data,
    // power-down pin
    input  wire logic                          standby_request_n,
    // memory channel
    output logic [7:0]                         mem_feedback_div_q,
    output logic [7:0]                         mem_ref_div_q,
    output logic [7:0]                         mem_post_div_q,
    output logic                               mem_prescale4_q,
    output logic                               mem_vco_enable_q,
    output dpd_pkg::dpd_out_mode_t             mem_out_mode_q,
    output logic                               standby_memclk_freq,
    // video channel
    output logic [7:0]                         vid_feedback_div_q,
    output logic [7:0]                         vid_ref_div_q,
    output logic [7:0]                         vid_post_div_q,
    output logic                               vid_prescale4_q,
    output logic                               vid_vco_enable_q,
    output logic                               vid_from_mem_q,
    output dpd_pkg::dpd_out_mode_t             vid_out_mode_q,
    // power state
    output logic                               osc_enable_q,
    output dpd_pkg::dpd_state_t                state_q,
    output logic [5:0]                         standby_divisor_q
);
    function automatic logic [7:0] fb_div(input logic [dpd_pkg::WORD_W-1:0] w);
        fb_div = {1'b0, w[dpd_pkg::FB_LSB +: dpd_pkg::FB_W]} + dpd_pkg::FB_OFFSET;
    endfunction

    function automatic logic [7:0] ref_div(input logic [dpd_pkg::WORD_W-1:0] w);
        ref_div = {1'b0, w[dpd_pkg::REF_LSB +: dpd_pkg::REF_W]} + dpd_pkg::REF_OFFSET;
    endfunction

    function automatic logic [7:0] post_div(input logic [dpd_pkg::WORD_W-1:0] w);
        post_div = 8'h01 << w[dpd_pkg::POST_LSB +: dpd_pkg::POST_W];
    endfunction

    function automatic logic [3:0] idx(input logic [dpd_pkg::WORD_W-1:0] w);
        idx = w[dpd_pkg::IDX_LSB +: dpd_pkg::IDX_W];
    endfunction

    function automatic logic [5:0] sb_divisor(input logic [3:0] v);
        sb_divisor = (v == 4'h0) ? 6'h00 : dpd_pkg::SB_DIV_BASE - {1'b0, v, 1'b0};
    endfunction

    logic [dpd_pkg::WORD_W-1:0] word_q [3];
    logic [2:0]                 prescale_q;
    logic                       standby_mode_select_q;
    logic [3:0]                 standby_div_q;
    logic [dpd_pkg::WORD_W-1:0] mem_word;
    logic [dpd_pkg::WORD_W-1:0] vid_word;
    logic                       vid_ps;
    logic                       normal;

    assign normal   = (state_q == dpd_pkg::ST_NORMAL);
    assign mem_word = word_q[dpd_pkg::ADDR_MEM];
    assign vid_word = video_select ? word_q[dpd_pkg::ADDR_VID1] : word_q[dpd_pkg::ADDR_VID0];
    assign vid_ps   = video_select ? prescale_q[1] : prescale_q[0];

    // word registers; loads refused outside normal so settings survive standby
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 3; i++)
            begin
                word_q[i] <= dpd_pkg::WORD_RST;
            end
        end
        else if (word_we && normal && word_addr <= dpd_pkg::ADDR_MEM)
        begin
            word_q[word_addr] <= word_data;
        end
    end

    // control bits and standby divider register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            standby_mode_select_q <= dpd_pkg::MODE_SEL_RST;
            prescale_q            <= dpd_pkg::PRESCALE_RST;
            standby_div_q         <= dpd_pkg::SB_DIV_RST;
        end
        else if (normal)
        begin
            if (control_word_we)
            begin
                standby_mode_select_q <= control_word[dpd_pkg::CTRL_MODE_BIT];
                prescale_q <= {control_word[dpd_pkg::CTRL_PS2_BIT],
                               control_word[dpd_pkg::CTRL_PS1_BIT],
                               control_word[dpd_pkg::CTRL_PS0_BIT]};
            end
            if (standby_div_we)
            begin
                standby_div_q <= standby_div_data;
            end
        end
    end

    // power state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= dpd_pkg::ST_NORMAL;
        end
        else
        begin
            unique case (state_q)
                dpd_pkg::ST_NORMAL:
                begin
                    if (!standby_request_n)
                    begin
                        state_q <= standby_mode_select_q ? dpd_pkg::ST_STANDBY2
                                                         : dpd_pkg::ST_STANDBY1;
                    end
                end
                dpd_pkg::ST_STANDBY1, dpd_pkg::ST_STANDBY2:
                begin
                    if (standby_request_n)
                    begin
                        state_q <= dpd_pkg::ST_NORMAL;
                    end
                end
                default:
                begin
                    state_q <= dpd_pkg::ST_NORMAL;
                end
            endcase
        end
    end

    // divider decode for both channels
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_feedback_div_q <= 8'h00;
            mem_ref_div_q      <= 8'h00;
            mem_post_div_q     <= 8'h00;
            mem_prescale4_q    <= 1'b0;
            vid_feedback_div_q <= 8'h00;
            vid_ref_div_q      <= 8'h00;
            vid_post_div_q     <= 8'h00;
            vid_prescale4_q    <= 1'b0;
            standby_divisor_q  <= 6'h00;
        end
        else
        begin
            mem_feedback_div_q <= fb_div(mem_word);
            mem_ref_div_q      <= ref_div(mem_word);
            mem_post_div_q     <= post_div(mem_word);
            mem_prescale4_q    <= prescale_q[2];
            vid_feedback_div_q <= fb_div(vid_word);
            vid_ref_div_q      <= ref_div(vid_word);
            vid_post_div_q     <= post_div(vid_word);
            vid_prescale4_q    <= vid_ps;
            standby_divisor_q  <= sb_divisor(standby_div_q);
        end
    end

    // channel routing and output modes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_vco_enable_q <= 1'b0;
            vid_vco_enable_q <= 1'b0;
            vid_from_mem_q   <= 1'b0;
            osc_enable_q     <= 1'b0;
            mem_out_mode_q   <= dpd_pkg::OUT_OFF;
            vid_out_mode_q   <= dpd_pkg::OUT_OFF;
        end
        else
        begin
            unique case (state_q)
                dpd_pkg::ST_NORMAL:
                begin
                    osc_enable_q     <= 1'b1;
                    mem_vco_enable_q <= 1'b1;
                    mem_out_mode_q   <= dpd_pkg::OUT_RUN;
                    vid_from_mem_q   <= (idx(vid_word) == dpd_pkg::IDX_VID_FROM);
                    vid_vco_enable_q <= (idx(vid_word) != dpd_pkg::IDX_VID_FROM) &&
                                        (idx(vid_word) != dpd_pkg::IDX_VID_OFF);
                    vid_out_mode_q   <= (idx(vid_word) == dpd_pkg::IDX_VID_OFF) ? dpd_pkg::OUT_OFF
                                                                                 : dpd_pkg::OUT_RUN;
                end
                dpd_pkg::ST_STANDBY1:
                begin
                    osc_enable_q     <= 1'b1;
                    mem_vco_enable_q <= 1'b0;
                    vid_vco_enable_q <= 1'b0;
                    vid_from_mem_q   <= 1'b0;
                    mem_out_mode_q   <= dpd_pkg::OUT_STANDBY;
                    vid_out_mode_q   <= dpd_pkg::OUT_HIGH;
                end
                default:
                begin
                    osc_enable_q     <= 1'b0;
                    mem_vco_enable_q <= 1'b0;
                    vid_vco_enable_q <= 1'b0;
                    vid_from_mem_q   <= 1'b0;
                    mem_out_mode_q   <= dpd_pkg::OUT_OFF;
                    vid_out_mode_q   <= dpd_pkg::OUT_OFF;
                end
            endcase
        end
    end

    // standby memory clock, reference divided by the decoded divisor
    dpd_even_divider u_sb_div
    (
        .clk     (clk),
        .rst     (rst),
        .en      ((mem_out_mode_q == dpd_pkg::OUT_STANDBY) && (standby_divisor_q != 6'h00)),
        .divisor (standby_divisor_q),
        .clk_q   (standby_memclk_freq)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_fb_ref;
        1'b1 |=> (mem_feedback_div_q == fb_div($past(mem_word))) &&
                 (vid_ref_div_q == ref_div($past(vid_word)));
    endproperty
    a_fb_ref: assert property (p_fb_ref) else $error("divide decode wrong");

    property p_post;
        (mem_word[9:7] == 3'h7) |=> (mem_post_div_q == 8'h80);
    endproperty
    a_post: assert property (p_post) else $error("post divide wrong");

    property p_vid_off;
        normal && (idx(vid_word) == 4'hE) |=> (vid_out_mode_q == dpd_pkg::OUT_OFF) && mem_vco_enable_q;
    endproperty
    a_vid_off: assert property (p_vid_off) else $error("video not off");

    property p_borrow;
        normal && (idx(vid_word) == 4'hF)
            |=> !vid_vco_enable_q && mem_vco_enable_q && vid_from_mem_q &&
                (vid_post_div_q == post_div($past(vid_word)));
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow routing wrong");

    property p_enter1;
        normal && !standby_request_n && !standby_mode_select_q
            |=> (state_q == dpd_pkg::ST_STANDBY1) ##1 (vid_out_mode_q == dpd_pkg::OUT_HIGH) && !vid_vco_enable_q;
    endproperty
    a_enter1: assert property (p_enter1) else $error("standby one not entered");

    property p_sb_div;
        (standby_div_q == 4'h1) |=> (standby_divisor_q == 6'h20);
    endproperty
    a_sb_div: assert property (p_sb_div) else $error("standby divisor wrong");

    property p_sb2;
        (state_q == dpd_pkg::ST_STANDBY2) |=> !osc_enable_q && (mem_out_mode_q == dpd_pkg::OUT_OFF);
    endproperty
    a_sb2: assert property (p_sb2) else $error("standby two outputs on");

    property p_keep;
        !normal |=> $stable(word_q[0]) && $stable(word_q[2]) && $stable(standby_div_q);
    endproperty
    a_keep: assert property (p_keep) else $error("register changed in standby");

    property p_exit;
        !normal && standby_request_n |=> normal ##1 osc_enable_q;
    endproperty
    a_exit: assert property (p_exit) else $error("standby not left");

    c_sb1:    cover property (normal ##1 (state_q == dpd_pkg::ST_STANDBY1) ##[1:40] standby_memclk_freq);
    c_sb2:    cover property (normal ##1 (state_q == dpd_pkg::ST_STANDBY2) ##[1:10] normal);
    c_borrow: cover property (vid_from_mem_q);
endmodule

// *** shared/dpd_pkg.sv ***
// constants and types for the dual pll divider and power-down control
package dpd_pkg;
    // frequency word layout
    localparam int unsigned WORD_W     = 21;
    localparam int unsigned IDX_LSB    = 17;
    localparam int unsigned IDX_W      = 4;
    localparam int unsigned FB_LSB     = 10;
    localparam int unsigned FB_W       = 7;
    localparam int unsigned POST_LSB   = 7;
    localparam int unsigned POST_W     = 3;
    localparam int unsigned REF_LSB    = 0;
    localparam int unsigned REF_W      = 7;
    localparam logic [7:0]  FB_OFFSET  = 8'h03;
    localparam logic [7:0]  REF_OFFSET = 8'h02;

    // index codes
    localparam logic [3:0] IDX_VID_OFF  = 4'hE;
    localparam logic [3:0] IDX_VID_FROM = 4'hF;

    // word register addresses
    localparam logic [1:0] ADDR_VID0 = 2'h0;
    localparam logic [1:0] ADDR_VID1 = 2'h1;
    localparam logic [1:0] ADDR_MEM  = 2'h2;

    // control word bit positions
    localparam int unsigned CTRL_W         = 22;
    localparam int unsigned CTRL_MODE_BIT  = 21;
    localparam int unsigned CTRL_PS0_BIT   = 13;
    localparam int unsigned CTRL_PS1_BIT   = 14;
    localparam int unsigned CTRL_PS2_BIT   = 15;

    // reset values
    localparam logic [WORD_W-1:0] WORD_RST      = '0;
    localparam logic              MODE_SEL_RST  = 1'b0;
    localparam logic [2:0]        PRESCALE_RST  = 3'h0;
    localparam logic [3:0]        SB_DIV_RST    = 4'h8;

    // standby divider decode
    localparam logic [5:0] SB_DIV_BASE = 6'h22;

    typedef enum logic [1:0] {
        ST_NORMAL   = 2'b00,
        ST_STANDBY1 = 2'b01,
        ST_STANDBY2 = 2'b10
    } dpd_state_t;

    typedef enum logic [1:0] {
        OUT_RUN     = 2'b00,
        OUT_HIGH    = 2'b01,
        OUT_OFF     = 2'b10,
        OUT_STANDBY = 2'b11
    } dpd_out_mode_t;
endpackage

// *** src/dpd_even_divider.sv ***
// even divider making the low-rate standby memory clock
module dpd_even_divider
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // control
    input  wire logic       en,
    input  wire logic [5:0] divisor,
    // output
    output logic            clk_q
);
    logic [4:0] cnt_q;
    logic [4:0] half_m1;

    assign half_m1 = divisor[5:1] - 5'h01;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 5'h00;
            clk_q <= 1'b0;
        end
        else if (!en)
        begin
            cnt_q <= 5'h00;
            clk_q <= 1'b0;
        end
        else if (cnt_q >= half_m1)
        begin
            cnt_q <= 5'h00;
            clk_q <= ~clk_q;
        end
        else
        begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule

// *** bench/dpd_host_model.sv ***
// host model that loads words, control and divider, and drives the power-down pin
module dpd_host_model
(
    // clock
    input  wire logic        clk,
    // loads
    output logic             word_we,
    output logic [1:0]       word_addr,
    output logic [20:0]      word_data,
    output logic             video_select,
    output logic             control_word_we,
    output logic [21:0]      control_word,
    output logic             standby_div_we,
    output logic [3:0]       standby_div_data,
    // power-down pin
    output logic             standby_request_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        {word_we, word_addr, word_data, video_select} = '0;
        {control_word_we, control_word, standby_div_we, standby_div_data} = '0;
        standby_request_n = 1'b1;
    end

    // whole word in one strobe, outputs decoded on return
    task automatic load_word(input logic [1:0] a, input logic [20:0] w);
        @(negedge clk);
        word_addr = a;
        word_data = w;
        word_we   = 1'b1;
        @(negedge clk);
        word_we = 1'b0;
        @(negedge clk);
    endtask

    task automatic load_ctrl(input logic [21:0] c);
        @(negedge clk);
        control_word    = c;
        control_word_we = 1'b1;
        @(negedge clk);
        control_word_we = 1'b0;
        @(negedge clk);
    endtask

    task automatic load_div(input logic [3:0] v);
        @(negedge clk);
        standby_div_data = v;
        standby_div_we   = 1'b1;
        @(negedge clk);
        standby_div_we = 1'b0;
        @(negedge clk);
    endtask

    task automatic sel(input logic s);
        @(negedge clk);
        video_select = s;
        repeat (2) @(negedge clk);
    endtask

    // pin edge, state edge, output edge
    task automatic set_pin(input logic v);
        @(negedge clk);
        standby_request_n = v;
        repeat (3) @(negedge clk);
    endtask
endmodule

// *** bench/dpd_clock_ctrl_bench.sv ***
// self-checking bench for the divider decode and power-down control
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module dpd_clock_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk, rst, word_we, video_select, control_word_we, standby_div_we;
    logic                   standby_request_n, standby_memclk_freq, osc_enable_q;
    logic [1:0]             word_addr;
    logic [20:0]            word_data;
    logic [21:0]            control_word;
    logic [3:0]             standby_div_data;
    logic [7:0]             mem_feedback_div_q, mem_ref_div_q, mem_post_div_q;
    logic [7:0]             vid_feedback_div_q, vid_ref_div_q, vid_post_div_q;
    logic                   mem_prescale4_q, mem_vco_enable_q, vid_prescale4_q, vid_vco_enable_q;
    logic                   vid_from_mem_q, p;
    dpd_pkg::dpd_out_mode_t mem_out_mode_q, vid_out_mode_q;
    dpd_pkg::dpd_state_t    state_q;
    logic [5:0]             standby_divisor_q;
    int                     n_fail, check_count, cycles, n;

    dpd_clock_ctrl uut (.clk, .rst, .word_we, .word_addr, .word_data, .video_select,
        .control_word_we, .control_word, .standby_div_we, .standby_div_data, .standby_request_n,
        .mem_feedback_div_q, .mem_ref_div_q, .mem_post_div_q, .mem_prescale4_q, .mem_vco_enable_q,
        .mem_out_mode_q, .standby_memclk_freq, .vid_feedback_div_q, .vid_ref_div_q, .vid_post_div_q,
        .vid_prescale4_q, .vid_vco_enable_q, .vid_from_mem_q, .vid_out_mode_q, .osc_enable_q,
        .state_q, .standby_divisor_q);

    dpd_host_model host (.clk, .word_we, .word_addr, .word_data, .video_select, .control_word_we,
        .control_word, .standby_div_we, .standby_div_data, .standby_request_n);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_fail++;
            final_report;
        end
    end

    initial
    begin
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("divisor", 18, standby_divisor_q)
        `CHK("state", dpd_pkg::ST_NORMAL, state_q)
        // every post select, index codes on memory word run normally
        for (int r = 0; r < 8; r++)
        begin
            host.load_word(dpd_pkg::ADDR_MEM, {4'(14 + r % 2), 7'(r * 18 + 1), 3'(r), 7'(127 - r * 18)});
            `CHK("mem_fb", r * 18 + 4, mem_feedback_div_q)
            `CHK("mem_ref", 129 - r * 18, mem_ref_div_q)
            `CHK("mem_post", 1 << r, mem_post_div_q)
            `CHK("mem_mode", dpd_pkg::OUT_RUN, mem_out_mode_q)
        end
        // prescale bit per register
        host.load_ctrl(22'h00_8000);
        `CHK("mem_ps", 1, mem_prescale4_q)
        `CHK("vid_ps", 0, vid_prescale4_q)
        host.load_ctrl(22'h00_2000);
        `CHK("vid_ps0", 1, vid_prescale4_q)
        `CHK("mem_ps", 0, mem_prescale4_q)
        host.sel(1'b1);
        `CHK("vid_ps1", 0, vid_prescale4_q)
        host.load_ctrl(22'h00_4000);
        `CHK("vid_ps1", 1, vid_prescale4_q)
        // second video register: x4, n 18, m 18 keeps the vco at 100 MHz
        host.load_word(dpd_pkg::ADDR_VID1, {4'h0, 7'h0f, 3'h3, 7'h10});
        `CHK("vid1_fb", 18, vid_feedback_div_q)
        `CHK("vid1_ref", 18, vid_ref_div_q)
        `CHK("vid1_post", 8, vid_post_div_q)
        // address 3 names no register: nothing may change
        host.load_word(2'h3, {4'h0, 7'h00, 3'h0, 7'h00});
        `CHK("vid1_fb", 18, vid_feedback_div_q)
        `CHK("mem_fb", 130, mem_feedback_div_q)
        host.sel(1'b0);
        // video word, then off, then borrowed vco
        host.load_word(dpd_pkg::ADDR_VID0, {4'h0, 7'h0a, 3'h2, 7'h05});
        `CHK("vid_fb", 13, vid_feedback_div_q)
        `CHK("vid_ref", 7, vid_ref_div_q)
        `CHK("vid_post", 4, vid_post_div_q)
        `CHK("vid_mode", dpd_pkg::OUT_RUN, vid_out_mode_q)
        `CHK("vid_vco", 1, vid_vco_enable_q)
        host.load_word(dpd_pkg::ADDR_VID0, {4'he, 7'h0a, 3'h2, 7'h05});
        `CHK("vid_off", dpd_pkg::OUT_OFF, vid_out_mode_q)
        `CHK("mem_vco", 1, mem_vco_enable_q)
        host.load_word(dpd_pkg::ADDR_VID0, {4'hf, 7'h0a, 3'h5, 7'h05});
        `CHK("vid_from", 1, vid_from_mem_q)
        `CHK("vid_vco", 0, vid_vco_enable_q)
        `CHK("mem_vco", 1, mem_vco_enable_q)
        `CHK("vid_post", 32, vid_post_div_q)
        // standby divider decode, all sixteen values
        for (int v = 0; v < 16; v++)
        begin
            host.load_div(4'(v));
            `CHK("divisor", (v == 0) ? 0 : 34 - 2 * v, standby_divisor_q)
        end
        host.load_div(4'hd);
        // standby one
        host.load_ctrl(22'h00_0000);
        host.set_pin(1'b0);
        `CHK("state", dpd_pkg::ST_STANDBY1, state_q)
        `CHK("vid_mode", dpd_pkg::OUT_HIGH, vid_out_mode_q)
        `CHK("vid_vco", 0, vid_vco_enable_q)
        `CHK("mem_vco", 0, mem_vco_enable_q)
        `CHK("mem_mode", dpd_pkg::OUT_STANDBY, mem_out_mode_q)
        // divisor 8: four rises in 32 cycles
        p = standby_memclk_freq;
        n = 0;
        repeat (32)
        begin
            @(negedge clk);
            if (p === 1'b0 && standby_memclk_freq === 1'b1)
                n++;
            p = standby_memclk_freq;
        end
        `CHK("sb_rises", 4, n)
        host.load_word(dpd_pkg::ADDR_MEM, {4'h0, 7'h01, 3'h1, 7'h01});
        host.set_pin(1'b1);
        `CHK("state", dpd_pkg::ST_NORMAL, state_q)
        `CHK("mem_mode", dpd_pkg::OUT_RUN, mem_out_mode_q)
        `CHK("mem_vco", 1, mem_vco_enable_q)
        `CHK("mem_fb", 130, mem_feedback_div_q)
        // standby two: mode bit first, then pin
        host.load_ctrl(22'h20_0000);
        host.set_pin(1'b0);
        `CHK("state", dpd_pkg::ST_STANDBY2, state_q)
        `CHK("osc", 0, osc_enable_q)
        `CHK("mem_mode", dpd_pkg::OUT_OFF, mem_out_mode_q)
        `CHK("vid_mode", dpd_pkg::OUT_OFF, vid_out_mode_q)
        `CHK("sb_clk", 0, standby_memclk_freq)
        host.load_div(4'h1);
        host.set_pin(1'b1);
        `CHK("state", dpd_pkg::ST_NORMAL, state_q)
        `CHK("osc", 1, osc_enable_q)
        `CHK("divisor", 8, standby_divisor_q)
        `CHK("mem_ref", 3, mem_ref_div_q)
        `CHK("mem_post", 128, mem_post_div_q)
        final_report;
    end
endmodule
